// ==== design/pcie_rst_pkg.sv ====
// Behaviour
// - Narrow core I/O except reference, clock out and power-on reset is core-clock synchronous.
// - Generic PIPE narrow builds pass the synchronised reference clock to the core clock output.
// - Transceiver narrow builds derive a 125 MHz core clock output from reference.
// - Wide variant derives a 250 MHz core clock output from the reference clock.
// - Narrow variant gives an application clock of 125 or 62.5 MHz.
// - Active-low asynchronous power-on reset initialises sticky registers, PLL and serializer.
// - Sticky registers clear only on power-on reset, surviving all other resets.
// - With 100 or 156.25 MHz reference, core clock output stays low during power-on reset.
// - Narrow: active-high synchronous datapath reset clears datapath state machines.
// - Narrow: active-high synchronous configuration reset clears non-sticky configuration registers.
// - Wide only: one active-low asynchronous reset clears configuration and datapath.
// - Low-power-exit indication goes low when training leaves L2, high otherwise.
// - Hot-reset-exit indication pulses low one cycle on leaving hot reset.
// - Link-down indication goes low when link layer drops from up to down.
package pcie_rst_pkg;
  // Core clock period in nanoseconds
  localparam int CLK_PERIOD_NS = 100;

  // Link training state codes watched for exit events
  localparam int          LTSSM_W         = 5;
  localparam logic [4:0]  LTSSM_L2        = 5'h15;
  localparam logic [4:0]  LTSSM_HOT_RESET = 5'h1f;

  // Reference clock selection strap codes
  localparam logic [1:0]  REF_100         = 2'h0;
  localparam logic [1:0]  REF_125         = 2'h1;
  localparam logic [1:0]  REF_156         = 2'h2;

  // Strap bit positions in the synchronised pin bundle
  localparam int          STRAP_W         = 6;
  localparam int          POS_PIPE        = 0;
  localparam int          POS_WIDE        = 1;
  localparam int          POS_SLOW        = 2;
  localparam int          POS_REF_LO      = 3;
  localparam int          POS_REF_HI      = 4;
  localparam int          POS_REFCLK      = 5;

  // Configuration register widths and reset values
  localparam int          CFG_W           = 16;
  localparam logic [15:0] STICKY_RESET    = 16'h0000;
  localparam logic [15:0] CFG_RESET       = 16'h0000;

  // Clock divider half periods in core clock cycles
  localparam int          CORE_HALF       = 2;
  localparam int          WIDE_HALF       = 1;
  localparam int          APP_SLOW_HALF   = 4;
  localparam int          DIV_W           = 8;

  typedef enum logic [1:0] {
    DP_IDLE,
    DP_ACTIVE,
    DP_DRAIN
  } dp_state_t;
endpackage

// ==== design/bit_sync.sv ====
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_stage2;

  assign q_o = stage2;

  // Two flops per bit; only the second stage is read outside
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      next_stage1[i] = ce_i ? d_i[i] : stage1[i];
      next_stage2[i] = ce_i ? stage1[i] : stage2[i];
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        stage1[i] <= 1'b0;
        stage2[i] <= 1'b0;
      end else begin
        stage1[i] <= next_stage1[i];
        stage2[i] <= next_stage2[i];
      end
    end
  end
endmodule

// ==== design/clk_div.sv ====
`timescale 1ns/1ps
module clk_div
  import pcie_rst_pkg::*;
#(
  parameter int HALF = 2
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  input  wire logic run_i,
  output logic      clk_o
);
  localparam logic [DIV_W-1:0] LAST = DIV_W'(HALF - 1);

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic             level;
  logic             next_level;

  assign clk_o = level;

  // Toggle every HALF cycles while running, park low when stopped
  always_comb begin
    next_count = count;
    next_level = level;
    if (ce_i) begin
      if (!run_i) begin
        next_count = '0;
        next_level = 1'b0;
      end else if (count == LAST) begin
        next_count = '0;
        next_level = ~level;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= '0;
      level <= 1'b0;
    end else begin
      count <= next_count;
      level <= next_level;
    end
  end
endmodule

// ==== design/pcie_core_clock_reset_ctrl.sv ====
`timescale 1ns/1ps
module pcie_core_clock_reset_ctrl
  import pcie_rst_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  input  wire logic               ce_i,
  input  wire logic               ref_clock_i,
  input  wire logic               pipe_mode_i,
  input  wire logic               wide_variant_i,
  input  wire logic               app_clk_slow_i,
  input  wire logic [1:0]         ref_sel_i,
  input  wire logic               dp_reset_i,
  input  wire logic               cfg_reset_i,
  input  wire logic               wide_reset_n_i,
  input  wire logic [LTSSM_W-1:0] ltssm_state_i,
  input  wire logic               dl_up_i,
  input  wire logic               dp_enable_i,
  input  wire logic               sticky_wr_i,
  input  wire logic               cfg_wr_i,
  input  wire logic [CFG_W-1:0]   wr_data_i,
  output logic                    core_clock_out_o,
  output logic                    wide_core_clock_out_o,
  output logic                    app_clk_o,
  output logic                    low_power_exit_n_o,
  output logic                    hot_reset_exit_n_o,
  output logic                    link_down_exit_n_o,
  output logic [CFG_W-1:0]        sticky_o,
  output logic [CFG_W-1:0]        cfg_o,
  output logic [1:0]              dp_state_o
);
  // Synchronised strap pins and reference clock level
  logic [STRAP_W-1:0] pins_raw;
  logic [STRAP_W-1:0] pins_sync;

  // Straps captured once after power-on release
  logic               strap_done;
  logic               strap_pipe;
  logic               strap_wide;
  logic               strap_slow;
  logic [1:0]         strap_ref;
  logic               next_strap_done;
  logic               next_strap_pipe;
  logic               next_strap_wide;
  logic               next_strap_slow;
  logic [1:0]         next_strap_ref;

  // Wide combined reset, asserted asynchronously, released synchronously
  logic               wide_rst_n_comb;
  logic               wide_rst_ok;
  logic               dp_clear;
  logic               cfg_clear;

  // Divided clocks
  logic               narrow_run;
  logic               wide_run;
  logic               slow_run;
  logic               core_div;
  logic               wide_div;
  logic               slow_div;
  logic               core_clk_q;
  logic               wide_clk_q;
  logic               app_clk_q;
  logic               next_core_clk;
  logic               next_wide_clk;
  logic               next_app_clk;

  // Exit event detection
  logic [LTSSM_W-1:0] ltssm_q;
  logic               dl_up_q;
  logic               lp_exit_n;
  logic               hot_exit_n;
  logic               link_down_n;
  logic [LTSSM_W-1:0] next_ltssm;
  logic               next_dl_up;
  logic               next_lp_exit_n;
  logic               next_hot_exit_n;
  logic               next_link_down_n;

  // Configuration space and datapath state
  logic [CFG_W-1:0]   sticky;
  logic [CFG_W-1:0]   cfg;
  logic [CFG_W-1:0]   next_sticky;
  logic [CFG_W-1:0]   next_cfg;
  dp_state_t          dp_state;
  dp_state_t          next_dp_state;

  // Pin bundle into the synchroniser
  always_comb begin
    pins_raw             = '0;
    pins_raw[POS_PIPE]   = pipe_mode_i;
    pins_raw[POS_WIDE]   = wide_variant_i;
    pins_raw[POS_SLOW]   = app_clk_slow_i;
    pins_raw[POS_REF_LO] = ref_sel_i[0];
    pins_raw[POS_REF_HI] = ref_sel_i[1];
    pins_raw[POS_REFCLK] = ref_clock_i;
  end

  bit_sync #(
    .W      (STRAP_W)
  ) u_pin_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .d_i    (pins_raw),
    .q_o    (pins_sync)
  );

  // Reset synchroniser for the wide combined reset pin
  assign wide_rst_n_comb = nrst_i & wide_reset_n_i;

  bit_sync #(
    .W      (1)
  ) u_wide_rst_sync (
    .clk_i  (clk_i),
    .nrst_i (wide_rst_n_comb),
    .ce_i   (ce_i),
    .d_i    (1'b1),
    .q_o    (wide_rst_ok)
  );

  // Catch straps once the synchronised pins are settled after release
  always_comb begin
    next_strap_done = strap_done;
    next_strap_pipe = strap_pipe;
    next_strap_wide = strap_wide;
    next_strap_slow = strap_slow;
    next_strap_ref  = strap_ref;
    if (ce_i && !strap_done && wide_rst_ok) begin
      next_strap_done = 1'b1;
      next_strap_pipe = pins_sync[POS_PIPE];
      next_strap_wide = pins_sync[POS_WIDE];
      next_strap_slow = pins_sync[POS_SLOW];
      next_strap_ref  = pins_sync[POS_REF_HI:POS_REF_LO];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_done <= 1'b0;
      strap_pipe <= 1'b0;
      strap_wide <= 1'b0;
      strap_slow <= 1'b0;
      strap_ref  <= REF_100;
    end else begin
      strap_done <= next_strap_done;
      strap_pipe <= next_strap_pipe;
      strap_wide <= next_strap_wide;
      strap_slow <= next_strap_slow;
      strap_ref  <= next_strap_ref;
    end
  end

  // Divider enables per variant
  assign narrow_run = strap_done & ~strap_wide;
  assign wide_run   = strap_done & strap_wide;
  assign slow_run   = narrow_run & strap_slow;

  clk_div #(
    .HALF   (CORE_HALF)
  ) u_core_div (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .run_i  (narrow_run),
    .clk_o  (core_div)
  );

  clk_div #(
    .HALF   (WIDE_HALF)
  ) u_wide_div (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .run_i  (wide_run),
    .clk_o  (wide_div)
  );

  clk_div #(
    .HALF   (APP_SLOW_HALF)
  ) u_slow_div (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .run_i  (slow_run),
    .clk_o  (slow_div)
  );

  // Clock output selection, all parked low until straps are known
  always_comb begin
    next_core_clk = core_clk_q;
    next_wide_clk = wide_clk_q;
    next_app_clk  = app_clk_q;
    if (ce_i) begin
      next_core_clk = 1'b0;
      next_wide_clk = 1'b0;
      next_app_clk  = 1'b0;
      if (narrow_run && strap_pipe) begin
        next_core_clk = pins_sync[POS_REFCLK];
      end else if (narrow_run) begin
        next_core_clk = core_div;
      end
      if (wide_run) begin
        next_wide_clk = wide_div;
      end
      if (narrow_run) begin
        next_app_clk = strap_slow ? slow_div : core_div;
      end
    end
  end

  // Async power-on reset holds every clock output low
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      core_clk_q <= 1'b0;
      wide_clk_q <= 1'b0;
      app_clk_q  <= 1'b0;
    end else begin
      core_clk_q <= next_core_clk;
      wide_clk_q <= next_wide_clk;
      app_clk_q  <= next_app_clk;
    end
  end

  // Exit indications: one-cycle low pulse on each leaving transition
  always_comb begin
    next_ltssm       = ltssm_q;
    next_dl_up       = dl_up_q;
    next_lp_exit_n   = lp_exit_n;
    next_hot_exit_n  = hot_exit_n;
    next_link_down_n = link_down_n;
    if (ce_i) begin
      next_ltssm       = ltssm_state_i;
      next_dl_up       = dl_up_i;
      next_lp_exit_n   = !(ltssm_q == LTSSM_L2 &&
                           ltssm_state_i != LTSSM_L2);
      next_hot_exit_n  = !(ltssm_q == LTSSM_HOT_RESET &&
                           ltssm_state_i != LTSSM_HOT_RESET);
      next_link_down_n = !(dl_up_q && !dl_up_i);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ltssm_q     <= '0;
      dl_up_q     <= 1'b0;
      lp_exit_n   <= 1'b1;
      hot_exit_n  <= 1'b1;
      link_down_n <= 1'b1;
    end else begin
      ltssm_q     <= next_ltssm;
      dl_up_q     <= next_dl_up;
      lp_exit_n   <= next_lp_exit_n;
      hot_exit_n  <= next_hot_exit_n;
      link_down_n <= next_link_down_n;
    end
  end

  // Variant-dependent reset sources for datapath and configuration
  assign dp_clear  = strap_wide ? ~wide_rst_ok : dp_reset_i;
  assign cfg_clear = strap_wide ? ~wide_rst_ok : cfg_reset_i;

  // Sticky and non-sticky configuration registers
  always_comb begin
    next_sticky = sticky;
    next_cfg    = cfg;
    if (ce_i) begin
      if (sticky_wr_i) begin
        next_sticky = wr_data_i;
      end
      if (cfg_clear) begin
        next_cfg = CFG_RESET;
      end else if (cfg_wr_i) begin
        next_cfg = wr_data_i;
      end
    end
  end

  // Sticky state only knows the power-on reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sticky <= STICKY_RESET;
      cfg    <= CFG_RESET;
    end else begin
      sticky <= next_sticky;
      cfg    <= next_cfg;
    end
  end

  // Datapath state machine
  always_comb begin
    next_dp_state = dp_state;
    if (ce_i) begin
      if (dp_clear) begin
        next_dp_state = DP_IDLE;
      end else begin
        case (dp_state)
          DP_IDLE: begin
            if (dp_enable_i) begin
              next_dp_state = DP_ACTIVE;
            end
          end
          DP_ACTIVE: begin
            if (!dp_enable_i) begin
              next_dp_state = DP_DRAIN;
            end
          end
          DP_DRAIN: begin
            next_dp_state = DP_IDLE;
          end
          default: begin
            next_dp_state = DP_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dp_state <= DP_IDLE;
    end else begin
      dp_state <= next_dp_state;
    end
  end

  // All outputs come from flops on the core clock
  assign core_clock_out_o      = core_clk_q;
  assign wide_core_clock_out_o = wide_clk_q;
  assign app_clk_o             = app_clk_q;
  assign low_power_exit_n_o    = lp_exit_n;
  assign hot_reset_exit_n_o    = hot_exit_n;
  assign link_down_exit_n_o    = link_down_n;
  assign sticky_o              = sticky;
  assign cfg_o                 = cfg;
  assign dp_state_o            = dp_state;
endmodule

// ==== bench/pcie_core_clock_reset_ctrl_assertions.sv ====
`timescale 1ns/1ps
module pcie_clk_rst_checker
  import pcie_rst_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               nrst_i,
  input wire logic               pipe_mode_i,
  input wire logic               wide_variant_i,
  input wire logic               app_clk_slow_i,
  input wire logic               dp_reset_i,
  input wire logic               cfg_reset_i,
  input wire logic [LTSSM_W-1:0] ltssm_state_i,
  input wire logic               dl_up_i,
  input wire logic               sticky_wr_i,
  input wire logic [CFG_W-1:0]   wr_data_i,
  input wire logic               core_clock_out_o,
  input wire logic               wide_core_clock_out_o,
  input wire logic               app_clk_o,
  input wire logic               low_power_exit_n_o,
  input wire logic               hot_reset_exit_n_o,
  input wire logic               link_down_exit_n_o,
  input wire logic [CFG_W-1:0]   sticky_o,
  input wire logic [CFG_W-1:0]   cfg_o,
  input wire logic [1:0]         dp_state_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Exit indications tied to their causes
  a_low_power_exit_n_low: assert property (
    $past(ltssm_state_i) == LTSSM_L2 && ltssm_state_i != LTSSM_L2
    |=> !low_power_exit_n_o) else $error("low power exit missing");
  a_hot_one_cycle: assert property (
    !hot_reset_exit_n_o |-> $past(ltssm_state_i, 2) == LTSSM_HOT_RESET
    && $past(ltssm_state_i) != LTSSM_HOT_RESET ##1 hot_reset_exit_n_o)
    else $error("hot reset exit pulse wrong");
  a_link_down_low: assert property (
    $fell(dl_up_i) |=> !link_down_exit_n_o)
    else $error("link down exit missing");
  // Register clears and sticky behaviour
  a_cfg_sync_clear: assert property (
    cfg_reset_i && !wide_variant_i |=> cfg_o == CFG_RESET)
    else $error("cfg not cleared");
  a_dp_sync_clear: assert property (
    dp_reset_i && !wide_variant_i |=> dp_state_o == DP_IDLE)
    else $error("datapath not idle");
  a_sticky_kept: assert property (
    !sticky_wr_i |=> $stable(sticky_o)) else $error("sticky changed");
  a_sticky_write: assert property (
    sticky_wr_i |=> sticky_o == $past(wr_data_i))
    else $error("sticky write lost");
  // Clock output shapes
  a_core_half_period: assert property (
    $rose(core_clock_out_o) && !pipe_mode_i
    |-> core_clock_out_o [*2] ##1 !core_clock_out_o)
    else $error("core clock period wrong");
  a_app_slow_period: assert property (
    $rose(app_clk_o) && app_clk_slow_i |-> app_clk_o [*4] ##1 !app_clk_o)
    else $error("slow app clock period wrong");
  a_wide_toggle: assert property (
    wide_core_clock_out_o |=> !wide_core_clock_out_o)
    else $error("wide clock not toggling");
  a_clocks_low_por: assert property (
    disable iff (1'b0) !nrst_i
    |-> !core_clock_out_o && !wide_core_clock_out_o && !app_clk_o)
    else $error("clock runs in power-on reset");

  // Main scenarios reached
  c_hot_exit: cover property (!hot_reset_exit_n_o);
  c_cfg_clear: cover property (cfg_reset_i ##1 cfg_o == CFG_RESET);
  c_wide_clock: cover property ($rose(wide_core_clock_out_o));
endmodule

// ==== bench/app_reset_gen.sv ====
`timescale 1ns/1ps
module app_reset_gen (
  input  wire logic clk_i,
  input  wire logic por_gen_n_i,
  input  wire logic perst_n_i,
  input  wire logic wide_i,
  input  wire logic dp_req_i,
  input  wire logic cfg_req_i,
  input  wire logic wide_req_i,
  input  wire logic low_power_exit_n_i,
  input  wire logic hot_reset_exit_n_i,
  input  wire logic link_down_exit_n_i,
  output logic      por_n_o,
  output logic      dp_reset_o,
  output logic      cfg_reset_o,
  output logic      wide_reset_n_o
);
  logic [1:0] hold;
  logic       exit_seen;
  logic       busy;

  // Power-on reset from generator and slot reset, both active low
  assign por_n_o = por_gen_n_i & perst_n_i;
  // Exit indications turned into resets on this side
  assign exit_seen = !(low_power_exit_n_i && hot_reset_exit_n_i
                       && link_down_exit_n_i);
  assign busy = hold != 2'h0;

  // Keeps the resets up for two cycles after any exit
  always_ff @(posedge clk_i or negedge por_n_o) begin
    if (!por_n_o) begin
      hold <= 2'h0;
    end else if (exit_seen) begin
      hold <= 2'h2;
    end else if (busy) begin
      hold <= hold - 2'h1;
    end
  end

  // Narrow builds get both sync resets, wide builds the combined one
  assign dp_reset_o = (!wide_i && busy) || dp_req_i;
  assign cfg_reset_o = (!wide_i && busy) || cfg_req_i;
  assign wide_reset_n_o = !(wide_i && busy) && !wide_req_i;
endmodule

// ==== bench/pcie_core_clock_reset_ctrl_bench.sv ====
`timescale 1ns/1ps
module pcie_core_clock_reset_ctrl_bench
  import pcie_rst_pkg::*;
;
  logic               clk_i, ce_i, ref_clock_i, pipe_mode_i, wide_variant_i;
  logic               app_clk_slow_i, dl_up_i, dp_enable_i, sticky_wr_i;
  logic               cfg_wr_i, por_gen_n, perst_n, dp_req, cfg_req, wide_req;
  logic [1:0]         ref_sel_i;
  logic [LTSSM_W-1:0] ltssm_state_i;
  logic [CFG_W-1:0]   wr_data_i;
  logic               nrst_i, dp_reset_i, cfg_reset_i, wide_reset_n_i;
  logic               core_clock_out_o, wide_core_clock_out_o, app_clk_o;
  logic               low_power_exit_n_o, hot_reset_exit_n_o;
  logic               link_down_exit_n_o;
  logic [CFG_W-1:0]   sticky_o, cfg_o;
  logic [1:0]         dp_state_o;
  int                 miscompares, tests_run;

  pcie_core_clock_reset_ctrl uut (.*);

  app_reset_gen app (
    .clk_i(clk_i), .por_gen_n_i(por_gen_n), .perst_n_i(perst_n),
    .wide_i(wide_variant_i), .dp_req_i(dp_req), .cfg_req_i(cfg_req),
    .wide_req_i(wide_req), .low_power_exit_n_i(low_power_exit_n_o),
    .hot_reset_exit_n_i(hot_reset_exit_n_o),
    .link_down_exit_n_i(link_down_exit_n_o), .por_n_o(nrst_i),
    .dp_reset_o(dp_reset_i), .cfg_reset_o(cfg_reset_i),
    .wide_reset_n_o(wide_reset_n_i)
  );

  // One core clock feeds every synchronous input
  initial begin
    clk_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Power-on reset with new straps, outputs checked while it is held
  task automatic power_up(input logic p, w, s, input logic [1:0] r);
    @(posedge clk_i);
    por_gen_n <= 1'b0;
    pipe_mode_i <= p;
    wide_variant_i <= w;
    app_clk_slow_i <= s;
    ref_sel_i <= r;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    chk("clocks", 16'h0000, {core_clock_out_o, wide_core_clock_out_o,
        app_clk_o});
    chk("exits", 16'h0007, {low_power_exit_n_o, hot_reset_exit_n_o,
        link_down_exit_n_o});
    chk("sticky", STICKY_RESET, sticky_o);
    chk("cfg", CFG_RESET, cfg_o);
    chk("dp", 16'h0000, dp_state_o);
    @(posedge clk_i);
    por_gen_n <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask

  function automatic logic pick(input int w);
    return w == 0 ? core_clock_out_o : (w == 1 ? app_clk_o
                                                : wide_core_clock_out_o);
  endfunction

  // Measures cycles between two changes of a clock output
  task automatic half_chk(input int w, input int half, input string what);
    logic v;
    int   n;
    @(negedge clk_i);
    v = pick(w);
    for (n = 0; n < 20 && pick(w) === v; n++) @(negedge clk_i);
    v = pick(w);
    for (n = 0; n < 20 && pick(w) === v; n++) @(negedge clk_i);
    chk(what, half[15:0], n[15:0]);
    if (n >= 20) begin
      miscompares++;
      test_done();
    end
  endtask

  task automatic t_regs;
    @(posedge clk_i);
    sticky_wr_i <= 1'b1;
    cfg_wr_i <= 1'b1;
    wr_data_i <= 16'hA5C3;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("cfg write", 16'hA5C3, cfg_o);
    @(posedge clk_i);
    sticky_wr_i <= 1'b0;
    cfg_wr_i <= 1'b0;
    dp_req <= 1'b1;
    cfg_req <= 1'b1;
    @(posedge clk_i);
    dp_req <= 1'b0;
    cfg_req <= 1'b0;
    @(negedge clk_i);
    chk("cfg cleared", CFG_RESET, cfg_o);
    chk("sticky kept", 16'hA5C3, sticky_o);
    @(posedge clk_i);
    perst_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("sticky on por", STICKY_RESET, sticky_o);
    @(posedge clk_i);
    perst_n <= 1'b1;
    repeat (6) @(posedge clk_i);
    $display("test regs done");
  endtask

  task automatic t_dp;
    @(posedge clk_i);
    dp_enable_i <= 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("dp active", DP_ACTIVE, dp_state_o);
    @(posedge clk_i);
    dp_req <= 1'b1;
    @(posedge clk_i);
    dp_req <= 1'b0;
    dp_enable_i <= 1'b0;
    @(negedge clk_i);
    chk("dp idle", DP_IDLE, dp_state_o);
    $display("test datapath done");
  endtask

  // Low_power_exit_n, hot reset exit and link down, each answered by resets
  task automatic t_exits;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      cfg_wr_i <= 1'b1;
      wr_data_i <= 16'hBEEF;
      if (k == 0) ltssm_state_i <= LTSSM_L2;
      else if (k == 1) ltssm_state_i <= LTSSM_HOT_RESET;
      else dl_up_i <= 1'b1;
      @(posedge clk_i);
      cfg_wr_i <= 1'b0;
      ltssm_state_i <= 5'h00;
      dl_up_i <= 1'b0;
      @(posedge clk_i);
      @(negedge clk_i);
      chk("exit low", 16'h0007 ^ (16'h0004 >> k), {low_power_exit_n_o,
          hot_reset_exit_n_o, link_down_exit_n_o});
      chk("cfg before", 16'hBEEF, cfg_o);
      @(negedge clk_i);
      chk("exit high", 16'h0007, {low_power_exit_n_o, hot_reset_exit_n_o,
          link_down_exit_n_o});
      repeat (4) @(negedge clk_i);
      chk("cfg after exit", CFG_RESET, cfg_o);
    end
    $display("test exits done");
  endtask

  task automatic t_clocks;
    power_up(1'b0, 1'b0, 1'b0, REF_125);
    half_chk(0, CORE_HALF, "core half");
    half_chk(1, CORE_HALF, "app fast half");
    power_up(1'b0, 1'b0, 1'b1, REF_156);
    half_chk(1, APP_SLOW_HALF, "app slow half");
    power_up(1'b1, 1'b0, 1'b0, REF_100);
    @(posedge clk_i);
    ref_clock_i <= 1'b1;
    repeat (4) @(negedge clk_i);
    chk("pipe high", 16'h0001, core_clock_out_o);
    // Clock enable low freezes the pass-through path
    @(posedge clk_i);
    ce_i <= 1'b0;
    ref_clock_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk("frozen by ce", 16'h0001, core_clock_out_o);
    @(posedge clk_i);
    ce_i <= 1'b1;
    repeat (4) @(negedge clk_i);
    chk("pipe low", 16'h0000, core_clock_out_o);
    $display("test clocks done");
  endtask

  task automatic t_wide;
    power_up(1'b0, 1'b1, 1'b0, REF_100);
    half_chk(2, WIDE_HALF, "wide half");
    @(posedge clk_i);
    cfg_wr_i <= 1'b1;
    wr_data_i <= 16'h5A5A;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
    cfg_req <= 1'b1;
    @(posedge clk_i);
    cfg_req <= 1'b0;
    @(negedge clk_i);
    chk("wide ignores sync", 16'h5A5A, cfg_o);
    @(posedge clk_i);
    wide_req <= 1'b1;
    @(posedge clk_i);
    wide_req <= 1'b0;
    @(negedge clk_i);
    chk("wide reset clears", CFG_RESET, cfg_o);
    $display("test wide done");
  endtask

  initial begin
    {ce_i, perst_n} = 2'h3;
    {ref_clock_i, pipe_mode_i, wide_variant_i, app_clk_slow_i} = 4'h0;
    {dl_up_i, dp_enable_i, sticky_wr_i, cfg_wr_i, por_gen_n} = 5'h00;
    {dp_req, cfg_req, wide_req, ref_sel_i} = 5'h00;
    ltssm_state_i = 5'h00;
    wr_data_i = 16'h0000;
    miscompares = 0;
    tests_run = 0;
    power_up(1'b0, 1'b0, 1'b0, REF_100);
    t_regs();
    t_dp();
    t_exits();
    t_clocks();
    t_wide();
    test_done();
  end
endmodule

bind pcie_core_clock_reset_ctrl pcie_clk_rst_checker chk_i (.*);
